//--- design/ddci_pkg.sv
// Package with constants, register map and states of the drive command interface.
package ddci_pkg;

    // ==========================================================
    // Clock and link timing
    // ==========================================================
    localparam int unsigned CLK_PERIOD_NS    = 50;
    localparam int unsigned CLK_RATE_KHZ     = 20000;
    localparam int unsigned PLO_RATE_KHZ     = 1900;
    localparam int unsigned PLO_HALF_CYC     = CLK_RATE_KHZ / (2 * PLO_RATE_KHZ);
    localparam int unsigned INDEX_MAX_NS     = 17000000;
    localparam int unsigned INDEX_TIMEOUT_DEF = INDEX_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned IDX_CNT_W        = 20;
    localparam int unsigned DIV_W            = 4;
    localparam int unsigned TMR_W            = 16;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [7:0]  REG_CTRL         = 8'h00;
    localparam logic [7:0]  REG_MOTION       = 8'h04;
    localparam logic [7:0]  REG_STATUS       = 8'h08;
    localparam logic [7:0]  REG_HEAD         = 8'h0C;
    localparam int unsigned CTRL_SEEK_FAIL   = 0;
    localparam int unsigned CTRL_SOFT_INIT   = 1;
    localparam logic [15:0] MOTION_RST       = 16'h0040;
    localparam logic [4:0]  SERVO_HEAD       = 5'h1F;
    localparam logic [2:0]  CYL_ZERO         = 3'h0;

    // ==========================================================
    // Synchroniser vector layout
    // ==========================================================
    localparam int unsigned SY_GO     = 0;
    localparam int unsigned SY_OFFMD  = 1;
    localparam int unsigned SY_OFFRST = 2;
    localparam int unsigned SY_RECAL  = 3;
    localparam int unsigned SY_INIT   = 4;
    localparam int unsigned SY_STBY   = 5;
    localparam int unsigned SY_WCMD   = 6;
    localparam int unsigned SY_RCMD   = 7;
    localparam int unsigned SY_LPERM  = 8;
    localparam int unsigned SY_CHAIN  = 9;
    localparam int unsigned SY_SEQEN  = 10;
    localparam int unsigned SY_LAMPA  = 11;
    localparam int unsigned SY_LAMPB  = 12;
    localparam int unsigned SY_START  = 13;
    localparam int unsigned SY_PACK   = 14;
    localparam int unsigned SY_DOOR   = 15;
    localparam int unsigned SY_WSTRB  = 16;
    localparam int unsigned SY_WDATA  = 17;
    localparam int unsigned SY_RDCH   = 18;
    localparam int unsigned SY_INDEX  = 19;
    localparam int unsigned SY_ABN    = 20;
    localparam int unsigned SY_UPSPD  = 21;
    localparam int unsigned SY_HOME   = 22;
    localparam int unsigned SY_HEAD   = 23;
    localparam int unsigned SY_CYL    = 28;
    localparam int unsigned SY_W      = 31;

    typedef enum logic [3:0] {
        ST_IDLE, ST_SPINUP, ST_SPUN, ST_LOADING, ST_READY, ST_SEEK, ST_OFFSETTING,
        ST_OFFSET_HELD, ST_CENTERING, ST_RECAL, ST_STBY, ST_RETRACT
    } ddci_state_t;

endpackage

//--- design/ddci_top.sv
// Drive-side command interface: sequencing, positioning commands, data path and register bus.
//
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module ddci_top
    import ddci_pkg::*;
#(
    parameter int unsigned INDEX_TIMEOUT_CYC = ddci_pkg::INDEX_TIMEOUT_DEF
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        go_pulse,
    input  wire logic        offset_mode,
    input  wire logic        offset_reset_pulse,
    input  wire logic        recal_req,
    input  wire logic        dev_init_pulse,
    input  wire logic        standby_req,
    input  wire logic        write_cmd,
    input  wire logic        read_cmd,
    input  wire logic        load_permit_in,
    input  wire logic        powerup_chain_in,
    input  wire logic        seq_enable_in,
    input  wire logic        port_a_lamp_in,
    input  wire logic        port_b_lamp_in,
    input  wire logic        start_switch,
    input  wire logic        pack_present,
    input  wire logic        door_closed,
    input  wire logic        write_strobe,
    input  wire logic        rw_data_i,
    input  wire logic        read_channel_in,
    input  wire logic        index_pulse,
    input  wire logic        abnormal_cause,
    input  wire logic        upspeed_reached,
    input  wire logic        heads_home,
    input  wire logic [4:0]  head_sel_in,
    input  wire logic [2:0]  cyl_high_in,
    output logic             file_ready,
    output logic             offset_ready,
    output logic             on_line,
    output logic             heads_retracted,
    output logic             seq_enable_out,
    output logic             standby_lamp,
    output logic             ready_lamp,
    output logic             port_a_lamp,
    output logic             port_b_lamp,
    output logic             retract_drive,
    output logic             brake,
    output logic             index_error,
    output logic             abnormal_stop,
    output logic             seek_incomplete,
    output logic             write_enable,
    output logic             read_enable,
    output logic [4:0]       head_select,
    output logic [2:0]       write_current,
    output logic [9:0]       offset_value,
    output logic             write_data,
    output logic             rw_data_o,
    output logic             rw_data_oe,
    output logic             read_strobe,
    output logic             pack_locked_clock
);
    import ddci_pkg::*;

    // ==========================================================
    // Input synchronisers and edge detection
    // ==========================================================
    logic [SY_W-1:0] async_in;
    logic [SY_W-1:0] meta_ff;
    logic [SY_W-1:0] sync_ff;
    logic [SY_W-1:0] prev_ff;
    logic [SY_W-1:0] rise;

    assign async_in = {cyl_high_in, head_sel_in, heads_home, upspeed_reached, abnormal_cause,
                       index_pulse, read_channel_in, rw_data_i, write_strobe, door_closed,
                       pack_present, start_switch, port_b_lamp_in, port_a_lamp_in,
                       seq_enable_in, powerup_chain_in, load_permit_in, read_cmd, write_cmd,
                       standby_req, dev_init_pulse, recal_req, offset_reset_pulse,
                       offset_mode, go_pulse};

    genvar gi;
    generate
        for (gi = 0; gi < SY_W; gi++) begin : g_sync
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    meta_ff[gi] <= 1'b0;
                    sync_ff[gi] <= 1'b0;
                    prev_ff[gi] <= 1'b0;
                end else begin
                    meta_ff[gi] <= async_in[gi];
                    sync_ff[gi] <= meta_ff[gi];
                    prev_ff[gi] <= sync_ff[gi];
                end
            end
            assign rise[gi] = sync_ff[gi] & ~prev_ff[gi];
        end
    endgenerate

    logic go_ev, offrst_ev, recal_ev, stby_ev, chain_ev, start_ev, init_ev;
    assign go_ev     = rise[SY_GO];
    assign offrst_ev = rise[SY_OFFRST];
    assign recal_ev  = rise[SY_RECAL];
    assign stby_ev   = rise[SY_STBY];
    assign chain_ev  = rise[SY_CHAIN];
    assign start_ev  = rise[SY_START];

    // ==========================================================
    // AHB-Lite slave, zero wait states
    // ==========================================================
    logic              wr_pend_ff;
    logic [7:0]        wr_addr_ff;
    logic [TMR_W-1:0]  motion_ff;
    logic              seek_fail_req;
    logic              soft_init;
    logic              addr_ok;
    logic [31:0]       rd_value;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_ok   = hsel && htrans[1] && hready;
    assign seek_fail_req = wr_pend_ff && (wr_addr_ff == REG_CTRL) && hwdata[CTRL_SEEK_FAIL];
    assign soft_init     = wr_pend_ff && (wr_addr_ff == REG_CTRL) && hwdata[CTRL_SOFT_INIT];
    assign init_ev       = rise[SY_INIT] || soft_init;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end else begin
            wr_pend_ff <= addr_ok && hwrite;
            wr_addr_ff <= haddr[7:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            motion_ff <= MOTION_RST;
        end else if (wr_pend_ff && wr_addr_ff == REG_MOTION) begin
            motion_ff <= hwdata[TMR_W-1:0];
        end
    end

    ddci_state_t state_ff, nxt_state;

    always_comb begin
        rd_value = 32'h0000_0000;
        case (haddr[7:0])
            REG_MOTION: rd_value = {16'h0000, motion_ff};
            REG_STATUS: rd_value = {16'h0000, 4'(state_ff), index_error, abnormal_stop,
                                    seek_incomplete, offset_ready, file_ready, on_line,
                                    heads_retracted, standby_lamp, seq_enable_out,
                                    write_enable, read_enable, brake};
            REG_HEAD:   rd_value = {14'h0000, offset_value, head_select, write_current};
            default:    rd_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata <= rd_value;
        end
    end

    // ==========================================================
    // Motion timer and operating sequence
    // ==========================================================
    logic [TMR_W-1:0] tmr_ff;
    logic             tmr_done;
    logic             standby_ff;
    logic             auto_recal_ff;
    logic             loaded_state;
    logic             can_start;

    assign tmr_done  = (tmr_ff == TMR_W'(0));
    assign can_start = sync_ff[SY_LPERM] && sync_ff[SY_CHAIN] && sync_ff[SY_SEQEN] &&
                       sync_ff[SY_PACK] && sync_ff[SY_DOOR];
    assign loaded_state = (state_ff == ST_READY) || (state_ff == ST_SEEK) ||
                          (state_ff == ST_OFFSETTING) || (state_ff == ST_OFFSET_HELD) ||
                          (state_ff == ST_CENTERING) || (state_ff == ST_RECAL) ||
                          (state_ff == ST_LOADING);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (standby_ff && start_ev && can_start) begin
                    nxt_state = ST_SPINUP;
                end else if (!standby_ff && chain_ev && sync_ff[SY_SEQEN] &&
                             sync_ff[SY_PACK] && sync_ff[SY_DOOR]) begin
                    nxt_state = ST_SPINUP;
                end
            end
            ST_SPINUP: if (sync_ff[SY_UPSPD]) begin
                nxt_state = ST_SPUN;
            end
            ST_SPUN: if (sync_ff[SY_LPERM] && !abnormal_stop) begin
                nxt_state = ST_LOADING;
            end
            ST_LOADING: if (tmr_done) begin
                nxt_state = ST_READY;
            end
            ST_READY, ST_OFFSET_HELD: begin
                if (go_ev) begin
                    nxt_state = sync_ff[SY_OFFMD] ? ST_OFFSETTING : ST_SEEK;
                end else if (offrst_ev && sync_ff[SY_OFFMD] && state_ff == ST_OFFSET_HELD) begin
                    nxt_state = ST_CENTERING;
                end else if (recal_ev || seek_fail_req) begin
                    nxt_state = ST_RECAL;
                end
            end
            ST_SEEK, ST_CENTERING, ST_RECAL: if (tmr_done) begin
                nxt_state = ST_READY;
            end
            ST_OFFSETTING: if (tmr_done) begin
                nxt_state = ST_OFFSET_HELD;
            end
            ST_STBY: nxt_state = ST_RETRACT;
            ST_RETRACT: if (sync_ff[SY_HOME]) begin
                nxt_state = standby_ff ? ST_IDLE : ST_SPUN;
            end
            default: nxt_state = ST_IDLE;
        endcase
        // Standby and loss of load permit take precedence over any motion in progress.
        if (loaded_state && stby_ev) begin
            nxt_state = ST_STBY;
        end else if (loaded_state && (!sync_ff[SY_LPERM] || abnormal_stop)) begin
            nxt_state = ST_RETRACT;
        end else if ((state_ff == ST_SPUN || state_ff == ST_SPINUP) && stby_ev) begin
            nxt_state = ST_RETRACT;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tmr_ff <= TMR_W'(0);
        end else if (nxt_state != state_ff) begin
            tmr_ff <= motion_ff;
        end else if (!tmr_done) begin
            tmr_ff <= tmr_ff - TMR_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            standby_ff <= 1'b0;
        end else if (stby_ev && state_ff != ST_IDLE) begin
            standby_ff <= 1'b1;
        end else if (state_ff == ST_IDLE && nxt_state == ST_SPINUP) begin
            standby_ff <= 1'b0;
        end
    end

    // Outputs follow the next state so that they change on the same edge as the state.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            file_ready      <= 1'b0;
            offset_ready    <= 1'b0;
            on_line         <= 1'b0;
            heads_retracted <= 1'b1;
            seq_enable_out  <= 1'b1;
            retract_drive   <= 1'b0;
            brake           <= 1'b0;
        end else begin
            file_ready      <= (nxt_state == ST_READY) || (nxt_state == ST_OFFSET_HELD) ||
                               (nxt_state == ST_STBY);
            offset_ready    <= (nxt_state == ST_OFFSET_HELD);
            on_line         <= (nxt_state != ST_IDLE) && (nxt_state != ST_SPINUP) &&
                               (nxt_state != ST_SPUN) && (nxt_state != ST_RETRACT) &&
                               (nxt_state != ST_LOADING);
            heads_retracted <= (nxt_state == ST_IDLE) || (nxt_state == ST_SPINUP) ||
                               (nxt_state == ST_SPUN);
            seq_enable_out  <= (nxt_state != ST_SPINUP);
            retract_drive   <= (nxt_state == ST_RETRACT);
            brake           <= (nxt_state == ST_IDLE) && standby_ff;
        end
    end

    assign standby_lamp = standby_ff;
    assign ready_lamp   = file_ready;
    assign port_a_lamp  = sync_ff[SY_LAMPA];
    assign port_b_lamp  = sync_ff[SY_LAMPB];

    // ==========================================================
    // Error latches
    // ==========================================================
    logic [IDX_CNT_W-1:0] idx_cnt_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            idx_cnt_ff  <= IDX_CNT_W'(0);
            index_error <= 1'b0;
        end else begin
            if (rise[SY_INDEX] || state_ff == ST_IDLE) begin
                idx_cnt_ff <= IDX_CNT_W'(0);
            end else if (idx_cnt_ff != IDX_CNT_W'(INDEX_TIMEOUT_CYC)) begin
                idx_cnt_ff <= idx_cnt_ff + IDX_CNT_W'(1);
            end
            // A missing index sets the flag; a fresh index pulse clears it.
            if (idx_cnt_ff == IDX_CNT_W'(INDEX_TIMEOUT_CYC) - IDX_CNT_W'(1) &&
                !rise[SY_INDEX]) begin
                index_error <= 1'b1;
            end else if (rise[SY_INDEX] || init_ev) begin
                index_error <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            abnormal_stop <= 1'b0;
        end else if (sync_ff[SY_ABN]) begin
            abnormal_stop <= 1'b1;
        end else if (sync_ff[SY_START] || init_ev) begin
            abnormal_stop <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            seek_incomplete <= 1'b0;
            auto_recal_ff   <= 1'b0;
        end else if (seek_fail_req) begin
            seek_incomplete <= 1'b1;
            auto_recal_ff   <= 1'b1;
        end else if (init_ev) begin
            seek_incomplete <= 1'b0;
            auto_recal_ff   <= 1'b0;
        end else if (auto_recal_ff && state_ff == ST_RECAL && tmr_done) begin
            seek_incomplete <= 1'b0;
            auto_recal_ff   <= 1'b0;
        end
    end

    // ==========================================================
    // Command arguments, head and write current
    // ==========================================================
    logic head_ok;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            write_current <= CYL_ZERO;
            offset_value  <= 10'h000;
        end else if (init_ev || nxt_state == ST_RECAL) begin
            write_current <= ~CYL_ZERO;
            offset_value  <= 10'h000;
        end else if (go_ev && (state_ff == ST_READY || state_ff == ST_OFFSET_HELD)) begin
            // Inner cylinders carry higher addresses and take less current.
            write_current <= ~sync_ff[SY_CYL +: 3];
            if (sync_ff[SY_OFFMD]) begin
                offset_value <= motion_ff[9:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            head_select <= 5'h00;
        end else begin
            head_select <= sync_ff[SY_HEAD +: 5];
        end
    end

    assign head_ok = (head_select != SERVO_HEAD);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            write_enable <= 1'b0;
            read_enable  <= 1'b0;
        end else begin
            // Both commands at once is unsafe, so neither channel is enabled.
            write_enable <= sync_ff[SY_WCMD] && !sync_ff[SY_RCMD] && on_line &&
                            head_ok;
            read_enable  <= sync_ff[SY_RCMD] && !sync_ff[SY_WCMD] && on_line &&
                            head_ok;
        end
    end

    // ==========================================================
    // Locked clock, strobes and serial data
    // ==========================================================
    logic [DIV_W-1:0] div_ff;
    logic             phase_ff;
    logic             half_tick;

    assign half_tick = (div_ff == DIV_W'(PLO_HALF_CYC - 1));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_ff   <= DIV_W'(0);
            phase_ff <= 1'b0;
        end else if (half_tick) begin
            div_ff   <= DIV_W'(0);
            phase_ff <= ~phase_ff;
        end else begin
            div_ff <= div_ff + DIV_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pack_locked_clock <= 1'b0;
            read_strobe       <= 1'b0;
        end else begin
            pack_locked_clock <= phase_ff && write_enable;
            read_strobe       <= phase_ff && read_enable;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rw_data_o  <= 1'b0;
            rw_data_oe <= 1'b0;
        end else begin
            rw_data_oe <= read_enable;
            // New read bit goes out as the strobe falls, so it is settled at the rise.
            if (read_strobe && !phase_ff) begin
                rw_data_o <= sync_ff[SY_RDCH];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            write_data <= 1'b0;
        end else if (rise[SY_WSTRB] && write_enable) begin
            write_data <= sync_ff[SY_WDATA];
        end
    end

endmodule // ddci_top

//--- verification/ddci_chk.sv
// Port checker of the drive command interface.
`timescale 1ns/1ps
module ddci_chk (
    input wire logic clk, rstn, port_a_lamp_in, port_a_lamp, ready_lamp, file_ready,
    input wire logic offset_ready, heads_retracted, on_line, brake, standby_lamp,
    input wire logic retract_drive, seq_enable_out, write_cmd, write_enable, rw_data_oe,
    input wire logic pack_locked_clock
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_stby; $rose(standby_lamp); endsequence
    sequence s_retr; retract_drive && !file_ready && !on_line; endsequence
    AST_LAMP: assert property (port_a_lamp_in [*5] |-> port_a_lamp)
        else $error("lamp not lit");
    AST_RDY: assert property (ready_lamp == file_ready) else $error("ready lamp");
    AST_STBY: assert property (s_stby |=> s_retr) else $error("standby order");
    AST_RET: assert property (heads_retracted |-> !on_line && !file_ready)
        else $error("ready while retracted");
    AST_BRK: assert property (brake |-> heads_retracted && !retract_drive)
        else $error("brake too early");
    AST_SEQ: assert property (!seq_enable_out |-> !file_ready) else $error("chain");
    AST_WEN: assert property (!write_cmd [*5] |-> !write_enable)
        else $error("write without command");
    AST_OE: assert property (rw_data_oe |-> !write_enable) else $error("line clash");
    AST_PLO: assert property (pack_locked_clock |-> $past(write_enable))
        else $error("locked clock without write");
    AST_OFF: assert property (offset_ready |-> file_ready && !heads_retracted)
        else $error("offset ready when unloaded");
endmodule // ddci_chk

bind ddci_top ddci_chk ddci_chk_inst (.*);

//--- verification/ddci_ctrl_model.sv
// Behavioural controller on the far side of the drive data link.
`timescale 1ns/1ps
module ddci_ctrl_model (
    input  wire logic clk, write_cmd, rw_data_oe, rw_data_o, read_strobe,
    output logic      write_strobe, rw_data_i, sent
);
    logic       wbit = 1'b0, last = 1'b0, rd_bit, sent_q = 1'b0;
    logic [2:0] n = 3'h0;
    // The strobe rests low between write frames and toggles every 200 ns, on a falling edge of clk.
    initial begin
        write_strobe = 1'b0;
        forever #200 write_strobe = write_cmd ? ~write_strobe : 1'b0;
    end
    always @(negedge write_strobe) {wbit, n} <= {n[0] ^ n[2], n + 3'h1};
    always @(posedge write_strobe) sent_q <= wbit;
    always @(posedge read_strobe) rd_bit <= rw_data_i;
    always @(posedge clk) last <= rw_data_i;
    // An undriven line flips every clock so a stale level never passes for data.
    assign rw_data_i = rw_data_oe ? rw_data_o : write_cmd ? wbit : ~last;
    assign sent = sent_q;
endmodule // ddci_ctrl_model

//--- verification/disk_drive_command_interface_tb.sv
// Self-checking bench of the drive command interface.
`timescale 1ns/1ps
`define CK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
    $display("wrong value at %0t: %h not %h", $time, a, b); end end
module disk_drive_command_interface_tb;
    import ddci_pkg::*;
    logic clk, rstn, hsel, hwrite, hready, hreadyout, hresp, offset_mode, write_cmd, read_cmd;
    logic go_pulse, offset_reset_pulse, recal_req, dev_init_pulse, standby_req, load_permit_in;
    logic powerup_chain_in, seq_enable_in, port_a_lamp_in, port_b_lamp_in, start_switch;
    logic pack_present, door_closed, write_strobe, rw_data_i, read_channel_in, index_pulse;
    logic abnormal_cause, upspeed_reached, heads_home, file_ready, offset_ready, on_line;
    logic heads_retracted, seq_enable_out, standby_lamp, ready_lamp, port_a_lamp, port_b_lamp;
    logic retract_drive, brake, index_error, abnormal_stop, seek_incomplete, write_enable;
    logic read_enable, write_data, rw_data_o, rw_data_oe, read_strobe, pack_locked_clock, sent;
    logic [31:0] haddr, hwdata, hrdata, rd, lf, m;
    logic [1:0]  htrans;
    logic [2:0]  hsize, cyl_high_in, write_current;
    logic [4:0]  head_sel_in, head_select, cmd, hs;
    logic [9:0]  offset_value;
    int          miscompares = 0, n_tests = 0, cyc = 0;
    assign hready = hreadyout;
    assign {standby_req, dev_init_pulse, recal_req, offset_reset_pulse, go_pulse} = cmd;
    ddci_top #(.INDEX_TIMEOUT_CYC(64)) ddci_top_inst (.*);
    ddci_ctrl_model ddci_ctrl_model_inst (.*);
    function automatic logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [2:0] wcur(input logic [2:0] c);
        return ~c;
    endfunction
    task summarize;
        $display("%0d checks, %0d miscompares", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, a};
        do @(posedge clk); while (hready !== 1'b1);
        {htrans, hwdata} <= {2'h0, d};
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // Pulses stay high and low long enough for the synchronisers to see them once.
    task pulse(input int i);
        cmd[i] <= 1'b1;
        repeat (4) @(posedge clk);
        cmd[i] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic wt(ref logic s, input logic v);
        for (int k = 0; k < 4000 && s !== v; k++) @(posedge clk);
        `CK(s, v)
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        index_pulse <= cyc[4:0] < 3;
        if (cyc == 30000) begin
            miscompares++;
            summarize();
        end
    end
    initial begin
        {rstn, hsel, hwrite, htrans, haddr, hwdata, cmd, offset_mode, write_cmd, read_cmd} = '0;
        {load_permit_in, powerup_chain_in, seq_enable_in, port_a_lamp_in, port_b_lamp_in} = '0;
        {start_switch, pack_present, door_closed, read_channel_in} = '0;
        {abnormal_cause, upspeed_reached, heads_home, cyl_high_in, head_sel_in} = '0;
        {hsize, lf} = {3'h2, 32'h1BBC3699};
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        ahb(1'b0, REG_STATUS, 0); `CK(rd, 32'h0000_0028)
        ahb(1'b0, REG_MOTION, 0); `CK(rd, {16'h0, MOTION_RST})
        ahb(1'b0, 32'h10, 0); `CK(rd, 32'h0)
        lf = nx(lf);
        m = 32'h10 + lf[5:0];
        ahb(1'b1, REG_MOTION, m);
        ahb(1'b0, REG_MOTION, 0); `CK(rd, m)
        $display("registers done");
        {pack_present, door_closed, seq_enable_in, load_permit_in} <= 4'hF;
        @(posedge clk) powerup_chain_in <= 1'b1;
        repeat (8) @(posedge clk);
        `CK(seq_enable_out, 1'b0)
        upspeed_reached <= 1'b1;
        wt(file_ready, 1'b1);
        `CK(seq_enable_out, 1'b1)
        offset_mode <= 1'b1;
        pulse(0);
        wt(offset_ready, 1'b1);
        `CK(offset_value, m[9:0])
        pulse(1);
        wt(offset_ready, 1'b0);
        offset_mode <= 1'b0;
        wt(file_ready, 1'b1);
        pulse(2);
        wt(file_ready, 1'b0);
        wt(file_ready, 1'b1);
        ahb(1'b1, REG_CTRL, 1);
        @(posedge clk) `CK(seek_incomplete, 1'b1)
        wt(seek_incomplete, 1'b0);
        $display("positioning done");
        for (int i = 0; i < 4; i++) begin
            lf = nx(lf);
            hs = (i == 0) ? SERVO_HEAD : {lf[4:1], 1'b0};
            {head_sel_in, cyl_high_in, port_a_lamp_in, port_b_lamp_in} <= {hs, lf[7:5], lf[9:8]};
            {read_channel_in, write_cmd} <= {lf[10], 1'b1};
            pulse(0);
            wt(file_ready, 1'b1);
            repeat (30) @(posedge clk);
            `CK(write_enable, hs !== SERVO_HEAD)
            `CK(write_current, wcur(lf[7:5]))
            `CK(port_a_lamp, lf[9])
            write_cmd <= 1'b0;
            repeat (10) @(posedge clk);
            `CK(write_data, (i == 0) ? 1'b0 : sent)
        end
        read_cmd <= 1'b1;
        repeat (30) @(posedge clk);
        `CK({read_enable, rw_data_oe}, 2'b11)
        `CK(ddci_ctrl_model_inst.rd_bit, read_channel_in)
        read_cmd <= 1'b0;
        $display("data path done");
        pulse(4);
        wt(retract_drive, 1'b1);
        `CK({standby_lamp, on_line, file_ready}, 3'b100)
        heads_home <= 1'b1;
        wt(brake, 1'b1);
        `CK(heads_retracted, 1'b1)
        pulse(3);
        `CK(seek_incomplete, 1'b0)
        $display("standby done");
        summarize();
    end
endmodule // disk_drive_command_interface_tb
